// *** gpe_pin_drive.sv ***
`timescale 1ns/100ps
// ==========================
// external pin drivers, prompt or slow
module gpe_pin_drive
(
   // clock
   input  wire logic                         clock,
   // requested levels and pace
   input  wire logic [gpe_pkg::PIN_COUNT-1:0] level_req,
   input  wire logic                         slow,
   // pins
   output logic [gpe_pkg::PIN_COUNT-1:0]     pin_out
);
   import gpe_pkg::*;
   logic [PIN_COUNT-1:0] stage_q [0:2];
   always_ff @(posedge clock)
   begin
      stage_q[0] <= level_req;
      stage_q[1] <= stage_q[0];
      stage_q[2] <= stage_q[1];
   end
   assign pin_out = slow ? stage_q[2] : stage_q[0];
endmodule

// *** gpe_pin_edge_irq.sv ***
`timescale 1ns/100ps
// Operation
// RL1 - polarity 0 detects rising edge, polarity 1 detects falling edge
// RL2 - bits 19..0 are data pins, bits 20..22 control pins one to three
// RL3 - bits 31..23 of polarity and pending read zero, writes ignored
// RL4 - polarity bits are read/write and reset to 0 (rising edge)
// RL5 - pending sets only if enabled, function-selected, input, and chosen edge
// RL6 - pending register is read-only, resets to 0, writes change nothing
// RL7 - any pending bit at 1 sets the summary pin flag
// RL8 - writing 1 to the clear alias clears that pending bit; 0 does nothing
// RL9 - clearing all pending bits leaves the summary flag; software clears it
// RL10 - summary flag sets again if cleared while any pending bit remains
// RL11 - pending 1 means outstanding interrupt on the pin, same bit mapping
// RL12 - clear alias is write-only and always reads as zero
// RL13 - enable bits 22..0 are read/write, reset 0, gate pending
// RL14 - edges found by comparing successive clock samples; edge beats clear
module gpe_pin_edge_irq
#(
   parameter int unsigned NUM_PINS = gpe_pkg::PIN_COUNT
)
(
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      srst,
   // register port
   input  wire gpe_pkg::gpe_bus_req_type  bus_req,
   output logic [gpe_pkg::DATA_W-1:0]     bus_rdata,
   // pins and pin configuration
   input  wire logic [NUM_PINS-1:0]       pin_in,
   input  wire logic [NUM_PINS-1:0]       pin_function_select,
   input  wire logic [NUM_PINS-1:0]       pin_direction,
   // status out
   output logic [NUM_PINS-1:0]            pin_irq_pending,
   output logic                           port_irq_status_gpio
);
   import gpe_pkg::*;

   // =========================================================
   // parameter check
   if (NUM_PINS < 1 || NUM_PINS > DATA_W)
   begin : g_bad_pins
      $error("NUM_PINS must lie between 1 and the data width");
   end

   // =========================================================
   // state
   logic [NUM_PINS-1:0] sync1_q;
   logic [NUM_PINS-1:0] smp_q;
   logic [NUM_PINS-1:0] prv_q;
   logic [NUM_PINS-1:0] en_q;
   logic [NUM_PINS-1:0] en_d;
   logic [NUM_PINS-1:0] pol_q;
   logic [NUM_PINS-1:0] pol_d;
   logic [NUM_PINS-1:0] pend_q;
   logic [NUM_PINS-1:0] pend_d;
   logic                flag_q;
   logic                flag_d;
   logic [DATA_W-1:0]   rdata_q;
   logic [DATA_W-1:0]   rdata_d;
   logic                prv_valid_q;

   // =========================================================
   // address decode
   wire logic hit_en   = bus_req.addr == OFS_IRQ_ENABLE;
   wire logic hit_pol  = bus_req.addr == OFS_IRQ_POLARITY;
   wire logic hit_pend = bus_req.addr == OFS_IRQ_PENDING;
   wire logic hit_clr  = bus_req.addr == OFS_IRQ_CLEAR;
   wire logic hit_stat = bus_req.addr == OFS_PORT_STATUS;

   wire logic wr_en   = bus_req.wr & hit_en;
   wire logic wr_pol  = bus_req.wr & hit_pol;
   wire logic wr_clr  = bus_req.wr & hit_clr;
   wire logic wr_stat = bus_req.wr & hit_stat;
   wire logic wr_pend = bus_req.wr & hit_pend;

   // only the low pin bits are kept; upper write bits fall away
   wire logic [NUM_PINS-1:0] wdata_pins = bus_req.wdata[NUM_PINS-1:0];

   // =========================================================
   // edge detection
   // RL14 sample compare
   wire logic [NUM_PINS-1:0] rise_w = smp_q & ~prv_q & {NUM_PINS{prv_valid_q}};
   wire logic [NUM_PINS-1:0] fall_w = ~smp_q & prv_q & {NUM_PINS{prv_valid_q}};

   // RL1 polarity edge select
   wire logic [NUM_PINS-1:0] sel_fall_w = pol_q ^ {NUM_PINS{POL_RISING}};
   wire logic [NUM_PINS-1:0] edge_w     = (rise_w & ~sel_fall_w) | (fall_w & sel_fall_w);

   // RL5 pin qualification
   wire logic [NUM_PINS-1:0] is_input_w = ~(pin_direction ^ {NUM_PINS{DIR_INPUT}});
   // RL13 enable gating
   wire logic [NUM_PINS-1:0] qual_w  = en_q & pin_function_select & is_input_w;
   wire logic [NUM_PINS-1:0] event_w = edge_w & qual_w;

   // RL8 write-one clear mask
   wire logic [NUM_PINS-1:0] clr_w = wdata_pins & {NUM_PINS{wr_clr}};

   wire logic flag_clr_w = wr_stat & bus_req.wdata[PORT_STATUS_GPIO_BIT];

   // =========================================================
   // next state
   // RL4 polarity storage
   assign pol_d = wr_pol ? wdata_pins : pol_q;
   // RL13 enable storage
   assign en_d = wr_en ? wdata_pins : en_q;
   // RL6 no direct write path
   // RL14 edge wins over clear
   assign pend_d = (pend_q & ~clr_w) | event_w;
   // RL7 pending sets flag
   // RL9 flag sticky
   // RL10 flag sets again
   assign flag_d = (flag_q & ~flag_clr_w) | (|pend_q) | (|event_w);

   // RL3 reserved bits zero
   // RL11 pending readback
   // RL12 clear alias reads zero
   assign rdata_d = !bus_req.rd ? '0 :
                    hit_en      ? DATA_W'(en_q) :
                    hit_pol     ? DATA_W'(pol_q) :
                    hit_pend    ? DATA_W'(pend_q) :
                    hit_stat    ? (DATA_W'(flag_q) << PORT_STATUS_GPIO_BIT) :
                    '0;

   // =========================================================
   // pin synchroniser
   // RL2 bit n follows pin n
   always_ff @(posedge clock)
   begin
      sync1_q <= pin_in;
      smp_q   <= sync1_q;
      prv_q   <= smp_q;
   end

   // =========================================================
   // registers
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         en_q        <= NUM_PINS'(RST_IRQ_ENABLE);
         pol_q       <= NUM_PINS'(RST_IRQ_POLARITY);
         pend_q      <= NUM_PINS'(RST_IRQ_PENDING);
         flag_q      <= RST_GPIO_FLAG;
         rdata_q     <= '0;
         prv_valid_q <= 1'b0;
      end
      else
      begin
         en_q        <= en_d;
         pol_q       <= pol_d;
         pend_q      <= pend_d;
         flag_q      <= flag_d;
         rdata_q     <= rdata_d;
         prv_valid_q <= 1'b1;
      end
   end

   assign bus_rdata            = rdata_q;
   assign pin_irq_pending      = pend_q;
   assign port_irq_status_gpio = flag_q;

   // =========================================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_rd_pol;
      bus_req.rd && hit_pol;
   endsequence

   sequence s_rd_clr;
      bus_req.rd && hit_clr;
   endsequence

   sequence s_rd_pend;
      bus_req.rd && hit_pend;
   endsequence

   property p_rise_only;
      1 |=> ((pend_q & ~$past(pend_q) & ~$past(pol_q) & ~$past(smp_q & ~prv_q)) == '0);
   endproperty
   a_rise_only: assert property (p_rise_only) // RL1
      else $error("rising-polarity event without rising edge");

   property p_fall_only;
      1 |=> ((pend_q & ~$past(pend_q) & $past(pol_q) & ~$past(prv_q & ~smp_q)) == '0);
   endproperty
   a_fall_only: assert property (p_fall_only) // RL1
      else $error("falling-polarity event without falling edge");

   property p_set_needs_event;
      1 |=> ((pend_q & ~$past(pend_q) & ~$past(event_w)) == '0);
   endproperty
   a_set_needs_event: assert property (p_set_needs_event) // RL5
      else $error("pending bit set without qualified edge");

   property p_enable_gate;
      1 |=> ((pend_q & ~$past(pend_q) & ~$past(en_q)) == '0)
            && ((pend_q & ~$past(pend_q) & ~$past(pin_function_select & is_input_w)) == '0);
   endproperty
   a_enable_gate: assert property (p_enable_gate) // RL13
      else $error("event on disabled or output pin");

   property p_edge_wins;
      (|event_w) |=> ((pend_q & $past(event_w)) == $past(event_w));
   endproperty
   a_edge_wins: assert property (p_edge_wins) // RL14
      else $error("qualified edge did not set pending");

   property p_clear;
      wr_clr |=> ((pend_q & $past(clr_w) & ~$past(event_w)) == '0)
                 && ((pend_q & ~$past(clr_w)) == ($past(pend_q | event_w) & ~$past(clr_w)));
   endproperty
   a_clear: assert property (p_clear) // RL8
      else $error("clear alias did not act bit by bit");

   property p_pend_ro;
      (wr_pend && event_w == '0) |=> $stable(pend_q);
   endproperty
   a_pend_ro: assert property (p_pend_ro) // RL6
      else $error("write changed pending register");

   property p_flag_follow;
      (|pend_q) |=> flag_q;
   endproperty
   a_flag_follow: assert property (p_flag_follow) // RL10
      else $error("summary flag not set while pending");

   property p_flag_hold;
      (flag_q && !flag_clr_w) |=> flag_q;
   endproperty
   a_flag_hold: assert property (p_flag_hold) // RL9
      else $error("summary flag dropped without explicit clear");

   property p_clr_zero;
      s_rd_clr |=> rdata_q == '0;
   endproperty
   a_clr_zero: assert property (p_clr_zero) // RL12
      else $error("clear alias read not zero");

   property p_pol_resv;
      s_rd_pol |=> ((rdata_q >> NUM_PINS) == '0)
                   && (rdata_q == DATA_W'($past(pol_q)));
   endproperty
   a_pol_resv: assert property (p_pol_resv) // RL3
      else $error("polarity read wrong or reserved bits set");

   property p_reset_vals;
      $fell(srst) |-> (en_q == NUM_PINS'(RST_IRQ_ENABLE))
                      && (pol_q == NUM_PINS'(RST_IRQ_POLARITY))
                      && (pend_q == NUM_PINS'(RST_IRQ_PENDING)) && (flag_q == RST_GPIO_FLAG);
   endproperty
   a_reset_vals: assert property (p_reset_vals) // RL4
      else $error("register not at reset value after reset");

   property p_pol_write;
      wr_pol |=> pol_q == $past(wdata_pins);
   endproperty
   a_pol_write: assert property (p_pol_write) // RL4
      else $error("polarity write not stored");

   property p_pol_hold;
      !wr_pol |=> $stable(pol_q);
   endproperty
   a_pol_hold: assert property (p_pol_hold) // RL4
      else $error("polarity changed without a write");

   property p_en_write;
      wr_en |=> en_q == $past(wdata_pins);
   endproperty
   a_en_write: assert property (p_en_write) // RL13
      else $error("enable write not stored");

   property p_flag_set;
      (|event_w) |=> flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set) // RL7
      else $error("summary flag not set by new pending bit");

   property p_pend_read;
      s_rd_pend |=> rdata_q == DATA_W'($past(pend_q));
   endproperty
   a_pend_read: assert property (p_pend_read) // RL11
      else $error("pending read does not match pending bits");

   property p_pend_hold;
      (clr_w == '0 && event_w == '0) |=> $stable(pend_q);
   endproperty
   a_pend_hold: assert property (p_pend_hold) // RL11
      else $error("pending bit changed without edge or clear");

   property p_flag_clear;
      (flag_clr_w && pend_q == '0 && event_w == '0) |=> !flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) // RL9
      else $error("summary flag not cleared by explicit clear");

   property p_rd_idle;
      !bus_req.rd |=> rdata_q == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) // RL3
      else $error("read data not zero outside a read");

   property p_clr_alias_only;
      wr_clr |=> $stable(pol_q) && $stable(en_q);
   endproperty
   a_clr_alias_only: assert property (p_clr_alias_only) // RL8
      else $error("clear alias write touched other registers");

endmodule

// *** gpe_pkg.sv ***
package gpe_pkg;

   // =========================================================
   // pin map
   localparam int unsigned PIN_COUNT      = 23;
   localparam int unsigned DATA_PIN_COUNT = 20;
   localparam int unsigned CTL_PIN_ONE    = 20;
   localparam int unsigned CTL_PIN_TWO    = 21;
   localparam int unsigned CTL_PIN_THREE  = 22;

   // =========================================================
   // register bus widths and offsets
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h00;
   localparam logic [7:0] OFS_IRQ_POLARITY = 8'h04;
   localparam logic [7:0] OFS_IRQ_PENDING  = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h0C;
   localparam logic [7:0] OFS_PORT_STATUS  = 8'h10;

   // =========================================================
   // field positions and reset values
   localparam int unsigned PORT_STATUS_GPIO_BIT = 0;
   localparam logic [31:0] RST_IRQ_ENABLE   = 32'h0000_0000;
   localparam logic [31:0] RST_IRQ_POLARITY = 32'h0000_0000;
   localparam logic [31:0] RST_IRQ_PENDING  = 32'h0000_0000;
   localparam logic        RST_GPIO_FLAG    = 1'b0;
   localparam logic        POL_RISING       = 1'b0;
   localparam logic        DIR_INPUT        = 1'b0;

   // =========================================================
   // register bus request
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } gpe_bus_req_type;

endpackage

// *** tb_gpe_pin_edge_irq.sv ***
`timescale 1ns/100ps
module tb_gpe_pin_edge_irq;
   import gpe_pkg::*;
   localparam logic [31:0] MASK = 32'h007F_FFFF;
   logic                  clock = 1'b0;
   logic                  srst = 1'b1;
   gpe_bus_req_type       bus_req = '0;
   logic [DATA_W-1:0]     bus_rdata;
   logic [PIN_COUNT-1:0]  pin_in, pend, lvl = '0, fsel = '1, dir = '0;
   logic                  slow = 1'b0, flag, rd_q = 1'b0;
   logic [31:0]           exp_q[$];
   logic [31:0]           pol, clr, st;
   int                    failures = 0, check_count = 0;

   always #25 clock = ~clock;
   gpe_pin_edge_irq dut (.clock(clock), .srst(srst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_function_select(fsel),
      .pin_direction(dir), .pin_irq_pending(pend), .port_irq_status_gpio(flag));
   gpe_pin_drive model (.clock(clock), .level_req(lvl), .slow(slow), .pin_out(pin_in));

   // ==========================
   // checking and closing
   task chk(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want)
      begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task test_done;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge clock) rd_q <= bus_req.rd;
   always @(negedge clock)
      if (rd_q)
         chk(bus_rdata, exp_q.pop_front());

   // ==========================
   // register bus and pins
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= d;
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge clock);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge clock);
      bus_req.rd <= 1'b0;
   endtask
   task pins(input logic [22:0] l, input logic [22:0] e);
      @(posedge clock);
      lvl <= l;
      repeat (9) @(negedge clock);
      chk(32'(pend), 32'(e));
   endtask
   task cfg(input logic [22:0] d, input logic [22:0] f);
      @(posedge clock);
      dir <= d;
      fsel <= f;
   endtask

   // ==========================
   // main sequence
   initial
   begin
      void'($urandom(32'h70d3d452));
      st = 32'h1 << PORT_STATUS_GPIO_BIT;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      rd(OFS_IRQ_ENABLE, RST_IRQ_ENABLE);
      rd(OFS_IRQ_POLARITY, RST_IRQ_POLARITY);
      rd(OFS_PORT_STATUS, 32'h0);
      wr(OFS_IRQ_PENDING, 32'hFFFF_FFFF);
      rd(OFS_IRQ_PENDING, RST_IRQ_PENDING);
      wr(OFS_IRQ_POLARITY, 32'hFFFF_FFFF);
      rd(OFS_IRQ_POLARITY, MASK);
      rd(OFS_IRQ_CLEAR, 32'h0);
      rd(8'h44, 32'h0);
      wr(OFS_IRQ_POLARITY, 32'h0);
      pins('1, '0);
      wr(OFS_IRQ_ENABLE, 32'hFFFF_FFFF);
      rd(OFS_IRQ_ENABLE, MASK);
      pins('0, '0);
      cfg('1, '1);
      pins('1, '0);
      cfg('0, '0);
      pins('0, '0);
      pins('1, '0);
      cfg('0, '1);
      pins('0, '0);
      chk(32'(flag), 32'h0);
      pol = $urandom & MASK;
      wr(OFS_IRQ_POLARITY, pol);
      slow <= 1'b1;
      pins('1, 23'(~pol));
      chk(32'(flag), 32'(|(~pol & MASK)));
      pins('0, '1);
      rd(OFS_IRQ_PENDING, MASK);
      wr(OFS_IRQ_PENDING, 32'h0);
      rd(OFS_IRQ_PENDING, MASK);
      clr = $urandom & 32'h007F_FFFE;
      wr(OFS_IRQ_CLEAR, clr | 32'hFF80_0000);
      rd(OFS_IRQ_PENDING, MASK & ~clr);
      wr(OFS_PORT_STATUS, st);
      rd(OFS_PORT_STATUS, st);
      wr(OFS_IRQ_CLEAR, 32'hFFFF_FFFF);
      rd(OFS_IRQ_PENDING, 32'h0);
      rd(OFS_PORT_STATUS, st);
      wr(OFS_PORT_STATUS, st);
      rd(OFS_PORT_STATUS, 32'h0);
      chk(32'(flag), 32'h0);
      wr(OFS_IRQ_POLARITY, 32'h0);
      pins(23'(32'h1 << CTL_PIN_THREE), 23'(32'h1 << CTL_PIN_THREE));
      chk(32'(flag), 32'h1);
      @(posedge clock);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      rd(OFS_IRQ_PENDING, RST_IRQ_PENDING);
      rd(OFS_IRQ_ENABLE, RST_IRQ_ENABLE);
      rd(OFS_PORT_STATUS, 32'h0);
      repeat (2) @(negedge clock);
      chk(32'(exp_q.size()), 32'h0);
      test_done();
   end
endmodule
